// ---- hdl/bf_pkg.sv ----
// Purpose: shared constants and types for the breaker failure supervision block
// Assumes: one evaluation tick per program cycle, delays counted in 5 ms steps
// Notes:   criterion, event and record layouts live here
package bf_pkg;
  localparam int TIME_STEP_US       = 5000;
  localparam int FAIL_DELAY_DEF     = 40;
  localparam int RETRIP_DELAY_DEF   = 20;
  localparam int DELAY_W            = 18;
  localparam int CNT_W              = 16;
  localparam int LOG_DEPTH          = 12;
  localparam int LOG_AW             = 4;
  localparam int STAMP_W            = 48;
  localparam int CUR_W              = 16;
  localparam int NUM_EVT            = 8;
  localparam int EVT_START          = 0;
  localparam int EVT_RETRIP         = 1;
  localparam int EVT_FAIL           = 2;
  localparam int EVT_BLOCK          = 3;
  localparam int EVT_DOMON          = 4;
  localparam int EVT_SIGNAL         = 5;
  localparam int EVT_PHASE          = 6;
  localparam int EVT_RES            = 7;
  localparam logic [1:0] SEL_ON     = 2'h1;
  localparam logic [1:0] SEL_OFF    = 2'h2;

  typedef enum logic [1:0] {
    CRIT_CURRENT = 2'b00,
    CRIT_CUR_AND_TRIP = 2'b01,
    CRIT_CUR_OR_TRIP = 2'b10,
    CRIT_DIG_INPUT = 2'b11
  } crit_t;

  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b00,
    ST_START   = 2'b01,
    ST_RETRIP  = 2'b10,
    ST_FAILED  = 2'b11
  } cond_t;

  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [2:0]         event_code;
    logic [CUR_W-1:0]   max_phase;
    logic [CUR_W-1:0]   residual;
    logic [DELAY_W-1:0] to_retrip;
    logic [DELAY_W-1:0] to_fail;
    logic [2:0]         group;
  } rec_t;

  typedef struct packed {
    logic               valid;
    logic [2:0]         code;
    logic               on;
    logic [STAMP_W-1:0] stamp;
  } evt_t;

  localparam int REC_W = $bits(rec_t);

  function automatic logic [DELAY_W-1:0] remaining(input logic [DELAY_W-1:0] lim,
                                                   input logic [DELAY_W-1:0] cnt);
    remaining = (cnt >= lim) ? '0 : lim - cnt;
  endfunction
endpackage

// ---- hdl/bf_log_mem.sv ----
// Purpose: record store for the most recent operation records
// Assumes: one write and one read per cycle
// Notes:   read data come from a register
module bf_log_mem #(
  parameter int DEPTH = 12,
  parameter int AW    = 4,
  parameter int W     = 8
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("depth exceeds address range");
  end

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
  end
endmodule

// ---- hdl/bf_supervisor.sv ----
// Purpose: breaker failure supervision with timers, events, counters and record log
// Assumes: TICK pulses once per evaluation step; inputs synchronous to CORE_CLK
// Notes:   delays are in 5 ms steps
// Functional notes
// - current criterion starts timer on phase or residual pick-up, trip ignored
// - current criterion clears timer when all currents drop below pick-up
// - current-and-trip criterion clears timer while trip output inactive
// - current-and-trip criterion counts only with trip active and current picked up
// - current-and-trip criterion clears when current or trip drops
// - current-or-trip criterion starts on either condition
// - current-or-trip pick-up stays until both conditions drop
// - failure output asserts once the timer has counted the failure delay
// - current-or-trip criterion clears only when both conditions drop
// - input mode starts timer only from digital input, optional qualifiers
// - input mode uses own trip output for failure purpose only
// - ON and OFF events with time stamps for eight status signals
// - per-event selection stores ON, OFF or both
// - resettable counts of retrip, failure, start and blocked
// - twelve newest records kept on ON events of start, retrip, failure and block, oldest overwritten
// - record holds stamp, event, phase, residual, remaining times, group
// - blocking at pick-up reports blocked and releases a running start
// - failure delay in 5 ms steps, default 200 ms
// - optional retrip timer from same pick-up, default 100 ms
module bf_supervisor
  import bf_pkg::*;
#(
  parameter int FAIL_DEF   = bf_pkg::FAIL_DELAY_DEF,
  parameter int RETRIP_DEF = bf_pkg::RETRIP_DELAY_DEF
) (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RST_B,
  input  wire logic                       CE,
  input  wire logic                       TICK,
  input  wire logic                       PHASE_PICKUP,
  input  wire logic                       RESIDUAL_PICKUP,
  input  wire logic                       TRIP_MONITOR,
  input  wire logic                       EXT_TRIP_IN,
  input  wire logic                       BLOCK_IN,
  input  wire logic [bf_pkg::STAMP_W-1:0] TIME_STAMP,
  input  wire logic [bf_pkg::CUR_W-1:0]   MAX_PHASE_CURRENT,
  input  wire logic [bf_pkg::CUR_W-1:0]   RESIDUAL_CURRENT,
  input  wire logic [2:0]                 SETTING_GROUP,
  input  wire logic [7:0]                 REG_ADDR,
  input  wire logic [31:0]                REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic      [31:0]                REG_RDATA,
  output logic                            BREAKER_FAILURE_OUTPUT,
  output logic                            RETRIP_OUTPUT,
  output logic                            FAILURE_TIMER_STARTED,
  output logic                            BLOCKED_OUT,
  output logic                            OWN_TRIP_OUTPUT,
  output bf_pkg::evt_t                    EVENT_OUT,
  output bf_pkg::rec_t                    RECORD_OUT
);
  import bf_pkg::*;

  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_FAIL_DLY  = 8'h04;
  localparam logic [7:0] A_RETR_DLY  = 8'h08;
  localparam logic [7:0] A_EVT_SEL   = 8'h0c;
  localparam logic [7:0] A_STATUS    = 8'h10;
  localparam logic [7:0] A_CNT_RETR  = 8'h14;
  localparam logic [7:0] A_CNT_FAIL  = 8'h18;
  localparam logic [7:0] A_CNT_START = 8'h1c;
  localparam logic [7:0] A_CNT_BLK   = 8'h20;
  localparam logic [7:0] A_CNT_CLR   = 8'h24;
  localparam logic [7:0] A_LOG_SEL   = 8'h28;
  localparam logic [7:0] A_LOG_W0    = 8'h2c;

  initial begin
    if (FAIL_DEF < 1 || FAIL_DEF >= (1 << DELAY_W)) $error("bad failure delay");
    if (RETRIP_DEF < 1 || RETRIP_DEF >= (1 << DELAY_W)) $error("bad retrip delay");
  end

  // control registers
  crit_t                crit_q;
  logic                 retrip_en_q;
  logic                 use_cur_q;
  logic                 use_mon_q;
  logic [DELAY_W-1:0]   fail_dly_q;
  logic [DELAY_W-1:0]   retr_dly_q;
  logic [2*NUM_EVT-1:0] evt_sel_q;
  logic [LOG_AW-1:0]    log_sel_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      crit_q      <= CRIT_CURRENT;
      retrip_en_q <= 1'b1;
      use_cur_q   <= 1'b0;
      use_mon_q   <= 1'b0;
      fail_dly_q  <= DELAY_W'(FAIL_DEF);
      retr_dly_q  <= DELAY_W'(RETRIP_DEF);
      evt_sel_q   <= '1;
      log_sel_q   <= '0;
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        A_CTRL: begin
          crit_q      <= crit_t'(REG_WDATA[1:0]);
          retrip_en_q <= REG_WDATA[2];
          use_cur_q   <= REG_WDATA[3];
          use_mon_q   <= REG_WDATA[4];
        end
        A_FAIL_DLY: fail_dly_q <= REG_WDATA[DELAY_W-1:0];
        A_RETR_DLY: retr_dly_q <= REG_WDATA[DELAY_W-1:0];
        A_EVT_SEL:  evt_sel_q  <= REG_WDATA[2*NUM_EVT-1:0];
        A_LOG_SEL:  log_sel_q  <= REG_WDATA[LOG_AW-1:0];
        default: ;
      endcase
    end
  end

  // sampled inputs, taken at each tick
  logic ph_q, rs_q, mon_q, ext_q, blk_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      {ph_q, rs_q, mon_q, ext_q, blk_q} <= '0;
    end else if (CE && TICK) begin
      {ph_q, rs_q, mon_q, ext_q, blk_q} <=
        {PHASE_PICKUP, RESIDUAL_PICKUP, TRIP_MONITOR, EXT_TRIP_IN, BLOCK_IN};
    end
  end

  // start condition per criterion
  logic cur_up, pickup, run;
  always_comb begin
    cur_up = ph_q | rs_q;
    pickup = 1'b0;
    run    = 1'b0;
    case (crit_q)
      CRIT_CURRENT: begin
        pickup = cur_up;
        run    = cur_up;
      end
      CRIT_CUR_AND_TRIP: begin
        pickup = cur_up;
        run    = cur_up & mon_q;
      end
      CRIT_CUR_OR_TRIP: begin
        pickup = cur_up | mon_q;
        run    = cur_up | mon_q;
      end
      CRIT_DIG_INPUT: begin
        run    = ext_q & (!use_cur_q | cur_up) & (!use_mon_q | mon_q);
        pickup = run;
      end
      default: begin
        pickup = 1'b0;
        run    = 1'b0;
      end
    endcase
  end

  // blocking and start state
  logic started_q, blocked_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      started_q <= 1'b0;
      blocked_q <= 1'b0;
    end else if (CE && TICK) begin
      blocked_q <= pickup & blk_q;
      started_q <= pickup & !blk_q;
    end
  end

  // timers
  logic [DELAY_W-1:0] fail_cnt_q, retr_cnt_q;
  logic               fail_q, retr_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      fail_cnt_q <= '0;
      retr_cnt_q <= '0;
      fail_q     <= 1'b0;
      retr_q     <= 1'b0;
    end else if (CE && TICK) begin
      if (!pickup || blk_q) begin
        fail_cnt_q <= '0;
        retr_cnt_q <= '0;
        fail_q     <= 1'b0;
        retr_q     <= 1'b0;
      end else if (run) begin
        if (fail_cnt_q < fail_dly_q) begin
          fail_cnt_q <= fail_cnt_q + 1'b1;
        end
        if (retr_cnt_q < retr_dly_q) begin
          retr_cnt_q <= retr_cnt_q + 1'b1;
        end
        fail_q <= (fail_cnt_q + 1'b1 >= fail_dly_q);
        retr_q <= retrip_en_q && (retr_cnt_q + 1'b1 >= retr_dly_q);
      end else if (crit_q == CRIT_CUR_AND_TRIP && !mon_q) begin
        fail_cnt_q <= '0;
        retr_cnt_q <= '0;
        fail_q     <= 1'b0;
        retr_q     <= 1'b0;
      end
    end
  end

  assign BREAKER_FAILURE_OUTPUT = fail_q;
  assign RETRIP_OUTPUT          = retr_q;
  assign FAILURE_TIMER_STARTED  = started_q;
  assign BLOCKED_OUT            = blocked_q;
  assign OWN_TRIP_OUTPUT        = (crit_q == CRIT_DIG_INPUT) ? fail_q : 1'b0;

  // event edge detection
  logic [NUM_EVT-1:0] stat_now, stat_prev_q, rise, fall;
  assign stat_now = {rs_q, ph_q, ext_q, mon_q, blocked_q, fail_q, retr_q, started_q};
  assign rise     = stat_now & ~stat_prev_q;
  assign fall     = ~stat_now & stat_prev_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      stat_prev_q <= '0;
    end else if (CE) begin
      stat_prev_q <= stat_now;
    end
  end

  // lowest pending event wins this cycle, others follow next cycles
  logic [NUM_EVT-1:0] pend_on_q, pend_off_q;
  logic [2:0]         pick_code;
  logic               pick_on, pick_any;
  always_comb begin
    pick_code = '0;
    pick_on   = 1'b0;
    pick_any  = 1'b0;
    for (int i = NUM_EVT - 1; i >= 0; i--) begin
      if (pend_on_q[i] || pend_off_q[i]) begin
        pick_code = 3'(i);
        pick_on   = pend_on_q[i];
        pick_any  = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      pend_on_q  <= '0;
      pend_off_q <= '0;
    end else if (CE) begin
      for (int i = 0; i < NUM_EVT; i++) begin
        // set wins over the clear of the taken slot
        if (rise[i] && evt_sel_q[2*i]) begin
          pend_on_q[i] <= 1'b1;
        end else if (pick_any && pick_on && pick_code == 3'(i)) begin
          pend_on_q[i] <= 1'b0;
        end
        if (fall[i] && evt_sel_q[2*i+1]) begin
          pend_off_q[i] <= 1'b1;
        end else if (pick_any && !pick_on && pick_code == 3'(i)) begin
          pend_off_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      EVENT_OUT <= '0;
    end else if (CE) begin
      EVENT_OUT.valid <= pick_any;
      EVENT_OUT.code  <= pick_code;
      EVENT_OUT.on    <= pick_on;
      EVENT_OUT.stamp <= TIME_STAMP;
    end
  end

  // cumulative counters
  logic [CNT_W-1:0] cnt_q [4];
  logic [3:0]       cnt_inc;
  assign cnt_inc = {rise[EVT_BLOCK], rise[EVT_START], rise[EVT_FAIL], rise[EVT_RETRIP]};
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < 4; i++) cnt_q[i] <= '0;
    end else if (CE) begin
      for (int i = 0; i < 4; i++) begin
        if (cnt_inc[i]) begin
          cnt_q[i] <= (REG_WR && REG_ADDR == A_CNT_CLR && REG_WDATA[i]) ?
                      CNT_W'(1) : cnt_q[i] + 1'b1;
        end else if (REG_WR && REG_ADDR == A_CNT_CLR && REG_WDATA[i]) begin
          cnt_q[i] <= '0;
        end
      end
    end
  end

  // operation record log on ON events of start, retrip, failure, block
  logic [LOG_AW-1:0] wptr_q;
  logic [LOG_AW:0]   fill_q;
  logic              log_we;
  logic [2:0]        log_code;
  rec_t              rec_new, rec_rd;
  always_comb begin
    log_we   = 1'b0;
    log_code = '0;
    for (int i = 3; i >= 0; i--) begin
      if (rise[i]) begin
        log_we   = 1'b1;
        log_code = 3'(i);
      end
    end
  end

  assign rec_new = '{stamp: TIME_STAMP, event_code: log_code,
                     max_phase: MAX_PHASE_CURRENT, residual: RESIDUAL_CURRENT,
                     to_retrip: remaining(retr_dly_q, retr_cnt_q),
                     to_fail: remaining(fail_dly_q, fail_cnt_q),
                     group: SETTING_GROUP};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      wptr_q <= '0;
      fill_q <= '0;
    end else if (CE && log_we) begin
      wptr_q <= (wptr_q == LOG_AW'(LOG_DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      if (fill_q < (LOG_AW + 1)'(LOG_DEPTH)) begin
        fill_q <= fill_q + 1'b1;
      end
    end
  end

  // log_sel 0 is newest record
  logic [LOG_AW-1:0] rd_idx;
  always_comb begin
    if (log_sel_q < wptr_q) begin
      rd_idx = wptr_q - 1'b1 - log_sel_q;
    end else begin
      rd_idx = LOG_AW'(LOG_DEPTH) + wptr_q - 1'b1 - log_sel_q;
    end
  end

  bf_log_mem #(.DEPTH(LOG_DEPTH), .AW(LOG_AW), .W(REC_W)) u_log (
    .clk   (CORE_CLK),
    .ce    (CE),
    .we    (log_we),
    .waddr (wptr_q),
    .wdata (rec_new),
    .raddr (rd_idx),
    .rdata (rec_rd)
  );
  assign RECORD_OUT = rec_rd;

  // register read, data one cycle after strobe
  cond_t cond;
  always_comb begin
    if (fail_q) cond = ST_FAILED;
    else if (retr_q) cond = ST_RETRIP;
    else if (started_q) cond = ST_START;
    else cond = ST_NORMAL;
  end

  logic [REC_W-1:0] rec_bits;
  assign rec_bits = rec_rd;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      REG_RDATA <= '0;
    end else if (CE) begin
      REG_RDATA <= '0;
      if (REG_RD) begin
        case (REG_ADDR)
          A_CTRL:      REG_RDATA <= {27'h0, use_mon_q, use_cur_q, retrip_en_q, crit_q};
          A_FAIL_DLY:  REG_RDATA <= 32'(fail_dly_q);
          A_RETR_DLY:  REG_RDATA <= 32'(retr_dly_q);
          A_EVT_SEL:   REG_RDATA <= 32'(evt_sel_q);
          A_STATUS:    REG_RDATA <= {20'h0, fill_q, blocked_q, stat_now[7:4], cond};
          A_CNT_RETR:  REG_RDATA <= 32'(cnt_q[0]);
          A_CNT_FAIL:  REG_RDATA <= 32'(cnt_q[1]);
          A_CNT_START: REG_RDATA <= 32'(cnt_q[2]);
          A_CNT_BLK:   REG_RDATA <= 32'(cnt_q[3]);
          A_LOG_SEL:   REG_RDATA <= 32'(log_sel_q);
          A_LOG_W0:        REG_RDATA <= rec_bits[31:0];
          A_LOG_W0 + 8'h4: REG_RDATA <= rec_bits[63:32];
          A_LOG_W0 + 8'h8: REG_RDATA <= rec_bits[95:64];
          A_LOG_W0 + 8'hc: REG_RDATA <= 32'(rec_bits[REC_W-1:96]);
          default:     REG_RDATA <= '0;
        endcase
      end
    end
  end
endmodule

// ---- sim/bf_sup_chk_assertions.sv ----
// Purpose: port checks for the breaker failure supervisor
// Assumes: one clock domain, synchronous active low reset
// Notes:   bound to every supervisor instance
module bf_sup_chk
  import bf_pkg::*;
#(
  parameter int FAIL_DEF   = 40,
  parameter int RETRIP_DEF = 20
) (
  input wire logic          CORE_CLK,
  input wire logic          RST_B,
  input wire logic          CE,
  input wire logic          TICK,
  input wire logic          BLOCK_IN,
  input wire logic          BREAKER_FAILURE_OUTPUT,
  input wire logic          RETRIP_OUTPUT,
  input wire logic          FAILURE_TIMER_STARTED,
  input wire logic          BLOCKED_OUT,
  input wire logic          OWN_TRIP_OUTPUT,
  input wire bf_pkg::evt_t  EVENT_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  // block level as the supervisor sees it, taken on each tick
  logic blk_smp_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) blk_smp_q <= 1'b0;
    else if (TICK && CE) blk_smp_q <= BLOCK_IN;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  AST_OWN_TRIP: assert property (OWN_TRIP_OUTPUT |->
    BREAKER_FAILURE_OUTPUT || $past(BREAKER_FAILURE_OUTPUT)) else $error("own trip alone");
  AST_FAIL_TICK: assert property ($changed(BREAKER_FAILURE_OUTPUT) |-> $past(TICK && CE))
    else $error("failure output moved off a tick");
  AST_RETRIP_TICK: assert property ($changed(RETRIP_OUTPUT) |-> $past(TICK && CE))
    else $error("retrip output moved off a tick");
  AST_START_TICK: assert property ($rose(FAILURE_TIMER_STARTED) |-> $past(TICK && CE))
    else $error("start rose off a tick");
  AST_FAIL_NEEDS_START: assert property (BREAKER_FAILURE_OUTPUT |-> FAILURE_TIMER_STARTED)
    else $error("failure output without start");
  AST_FAIL_CLEAR: assert property ($fell(FAILURE_TIMER_STARTED) |->
    !BREAKER_FAILURE_OUTPUT && !RETRIP_OUTPUT) else $error("outputs kept after clear");
  AST_BLOCK_CLEARS: assert property (BLOCKED_OUT |->
    !FAILURE_TIMER_STARTED && !BREAKER_FAILURE_OUTPUT) else $error("running while blocked");
  AST_BLOCK_CAUSE: assert property ($rose(BLOCKED_OUT) |->
    $past(blk_smp_q) && $past(TICK && CE))
    else $error("blocked without block input");
  AST_CE_FREEZE: assert property (!$past(CE) |-> $stable(BREAKER_FAILURE_OUTPUT) &&
    $stable(FAILURE_TIMER_STARTED) && $stable(RETRIP_OUTPUT)) else $error("moved while frozen");
  COV_FAIL: cover property ($rose(BREAKER_FAILURE_OUTPUT));
  COV_BLOCK: cover property ($rose(BLOCKED_OUT));
  COV_EVT: cover property (EVENT_OUT.valid);
  COV_OWN: cover property ($rose(OWN_TRIP_OUTPUT));
endmodule

bind bf_supervisor bf_sup_chk #(.FAIL_DEF(FAIL_DEF), .RETRIP_DEF(RETRIP_DEF)) bf_sup_chk_i (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CE(CE), .TICK(TICK), .BLOCK_IN(BLOCK_IN),
  .BREAKER_FAILURE_OUTPUT(BREAKER_FAILURE_OUTPUT), .RETRIP_OUTPUT(RETRIP_OUTPUT),
  .FAILURE_TIMER_STARTED(FAILURE_TIMER_STARTED), .BLOCKED_OUT(BLOCKED_OUT),
  .OWN_TRIP_OUTPUT(OWN_TRIP_OUTPUT), .EVENT_OUT(EVENT_OUT));

// ---- sim/bf_primary_model.sv ----
// Purpose: primary trip contact and upstream breaker beside the supervisor
// Assumes: trip contact closes one or six cycles after the primary trip
// Notes:   an armed upstream breaker opens on failure and kills the currents
module bf_primary_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ph_req,
  input  wire logic res_req,
  input  wire logic trip_req,
  input  wire logic slow,
  input  wire logic arm,
  input  wire logic fail,
  output logic      ph_pickup,
  output logic      res_pickup,
  output logic      trip_mon
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dly_q;
  logic       open_q;
  // upstream breaker opens on the failure command, recloses when disarmed
  always_ff @(posedge clk) begin
    if (!rst_b || !arm) open_q <= 1'b0;
    else if (fail) open_q <= 1'b1;
  end
  // contact delay line
  always_ff @(posedge clk) begin
    if (!rst_b) dly_q <= 8'h00;
    else dly_q <= {dly_q[6:0], trip_req};
  end
  assign trip_mon   = (slow ? dly_q[5] : dly_q[0]) && !open_q;
  assign ph_pickup  = ph_req && !open_q;
  assign res_pickup = res_req && !open_q;
endmodule

// ---- sim/breaker_failure_timer_logic_bench.sv ----
// Purpose: self-checking bench for the breaker failure supervisor
// Assumes: failure and retrip delays shortened to 3 and 2 steps
// Notes:   criteria and pickups swept, then drawn from a fixed seed
module breaker_failure_timer_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import bf_pkg::*;
  localparam int FD = 3;
  localparam int RD = 2;
  logic        CORE_CLK = 1'b0, RST_B = 1'b0, CE = 1'b1, TICK = 1'b0;
  logic        ph = 1'b0, rs = 1'b0, trq = 1'b0, ext = 1'b0, arm = 1'b0, slow = 1'b0;
  logic        BLOCK_IN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic        PHASE_PICKUP, RESIDUAL_PICKUP, TRIP_MONITOR, EXT_TRIP_IN;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
  logic [47:0] TIME_STAMP = 48'h1;
  logic [15:0] MAX_PHASE_CURRENT = 16'h0, RESIDUAL_CURRENT = 16'h0;
  logic [2:0]  SETTING_GROUP = 3'h0;
  logic        BREAKER_FAILURE_OUTPUT, RETRIP_OUTPUT, FAILURE_TIMER_STARTED;
  logic        BLOCKED_OUT, OWN_TRIP_OUTPUT;
  evt_t        EVENT_OUT;
  rec_t        RECORD_OUT;
  int          err_total = 0, cmp_count = 0, ev_n = 0, cyc = 0, c, e0;
  logic [3:0]  v;
  logic [1:0]  q;
  assign EXT_TRIP_IN = ext;
  bf_supervisor #(.FAIL_DEF(FD), .RETRIP_DEF(RD)) bf_supervisor_i (.*);
  bf_primary_model bf_primary_model_i (.clk(CORE_CLK), .rst_b(RST_B), .ph_req(ph),
    .res_req(rs), .trip_req(trq), .slow(slow), .arm(arm), .fail(BREAKER_FAILURE_OUTPUT),
    .ph_pickup(PHASE_PICKUP), .res_pickup(RESIDUAL_PICKUP), .trip_mon(TRIP_MONITOR));
  initial forever #2 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) TIME_STAMP <= TIME_STAMP + 48'h1;
  // a frozen cycle holds the event, so count it only where it is replaced
  always @(posedge CORE_CLK) if (CE && EVENT_OUT.valid === 1'b1) ev_n <= ev_n + 1;
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA & m, e);
  endtask
  // settle, then n ticks with a possibly frozen cycle after each
  task automatic tk(input int n);
    repeat (8) @(posedge CORE_CLK);
    repeat (n) begin
      @(posedge CORE_CLK);
      TICK <= 1'b1;
      @(posedge CORE_CLK);
      TICK <= 1'b0;
      CE <= 1'($urandom_range(1));
      @(posedge CORE_CLK);
      CE <= 1'b1;
    end
    #1;
  endtask
  function automatic logic sx(input int c, input logic [1:0] q, input logic [3:0] v);
    logic cur;
    cur = v[0] | v[1];
    case (c)
      0: return cur;
      1: return cur & v[2];
      2: return cur | v[2];
      default: return v[3] & (cur | !q[0]) & (v[2] | !q[1]);
    endcase
  endfunction
  // v = {input, trip, residual, phase}
  task automatic run(input int c, input logic [1:0] q, input logic [3:0] v);
    logic s;
    wr(8'h00, 32'(c) | 32'h4 | {27'h0, q, 3'h0});
    {ext, trq, rs, ph} <= v;
    s = sx(c, q, v);
    tk(FD - 1);
    chk(BREAKER_FAILURE_OUTPUT, 1'b0);
    chk(FAILURE_TIMER_STARTED, (c == 1) ? sx(0, q, v) : s);
    tk(2);
    chk(BREAKER_FAILURE_OUTPUT, s);
    chk(RETRIP_OUTPUT, s);
    chk(OWN_TRIP_OUTPUT, s && c == 3);
    {rs, ph} <= 2'b00;
    s = sx(c, q, v & 4'hc);
    tk(2);
    chk(BREAKER_FAILURE_OUTPUT, s);
    {ext, trq} <= 2'b00;
    tk(2);
    chk(FAILURE_TIMER_STARTED, 1'b0);
  endtask
  initial begin
    void'($urandom(32'hcc7b4451));
    MAX_PHASE_CURRENT <= 16'($urandom);
    RESIDUAL_CURRENT <= 16'($urandom);
    SETTING_GROUP <= 3'($urandom);
    repeat (16) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    rc(8'h00, 32'h4, 32'h1f);
    rc(8'h04, FD, 32'hffffffff);
    rc(8'h08, RD, 32'hffffffff);
    rc(8'h0c, 32'hffff, 32'hffff);
    wr(8'h3c, 32'hffffffff);
    rc(8'h3c, 32'h0, 32'hffffffff);
    for (int i = 0; i < 80; i++) begin
      c = (i < 64) ? i / 16 : $urandom_range(3);
      q = (i < 64) ? 2'h0 : 2'($urandom);
      v = (i < 64) ? 4'(i) : 4'($urandom);
      slow <= 1'($urandom);
      run(c, q, v);
    end
    rc(8'h10, 32'(LOG_DEPTH) << 7, 32'h1f << 7);
    wr(8'h00, 32'h4);
    arm <= 1'b1;
    ph <= 1'b1;
    tk(FD + 1);
    chk(BREAKER_FAILURE_OUTPUT, 1'b1);
    tk(2);
    chk(BREAKER_FAILURE_OUTPUT, 1'b0);
    arm <= 1'b0;
    ph <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(8'h0c, (k == 0) ? 32'hffff : (k == 1) ? 32'h5555 : (k == 2) ? 32'haaaa : 32'h1);
      tk(2);
      e0 = ev_n;
      run(0, 2'h0, 4'h1);
      repeat (30) @(posedge CORE_CLK);
      chk(ev_n - e0, (k == 0) ? 8 : (k == 3) ? 1 : 4);
    end
    wr(8'h24, 32'hf);
    ph <= 1'b1;
    tk(2);
    BLOCK_IN <= 1'b1;
    tk(2);
    chk(BLOCKED_OUT, 1'b1);
    chk(FAILURE_TIMER_STARTED, 1'b0);
    tk(FD);
    chk(BREAKER_FAILURE_OUTPUT, 1'b0);
    wr(8'h28, 32'h0);
    repeat (2) @(posedge CORE_CLK);
    #1 chk(RECORD_OUT.event_code, EVT_BLOCK);
    chk(RECORD_OUT.group, SETTING_GROUP);
    chk(RECORD_OUT.max_phase, MAX_PHASE_CURRENT);
    chk(RECORD_OUT.residual, RESIDUAL_CURRENT);
    chk(RECORD_OUT.to_fail, FD);
    chk(RECORD_OUT.to_retrip, RD);
    BLOCK_IN <= 1'b0;
    ph <= 1'b0;
    tk(2);
    rc(8'h14, 32'h1, 32'hffff);
    rc(8'h18, 32'h0, 32'hffff);
    rc(8'h1c, 32'h1, 32'hffff);
    rc(8'h20, 32'h1, 32'hffff);
    stop_test();
  end
endmodule
